// [hdl/mda_regs.svh]
// Register offsets, field positions and constants of the DMA controller
`ifndef MDA_REGS_SVH
`define MDA_REGS_SVH

// ==========================================================================
// Geometry
`define MDA_NUM_CH        12
`define MDA_DSC_STRIDE    12'h010
`define MDA_DSC_LIMIT     12'h0C0

// ==========================================================================
// Descriptor word offsets inside one channel slot
`define MDA_W_CTL         2'h0
`define MDA_W_SRC         2'h1
`define MDA_W_DST         2'h2
`define MDA_W_NEXT        2'h3

// ==========================================================================
// Global registers
`define MDA_OFS_SCAT_BASE 12'h400
`define MDA_OFS_SW_REQ    12'h404
`define MDA_OFS_FIXED_LVL 12'h408
`define MDA_OFS_INT_MASK  12'h40C
`define MDA_OFS_INT_STS   12'h410
`define MDA_OFS_STATUS    12'h414

// ==========================================================================
// Control word fields
`define MDA_F_OP          1:0
`define MDA_F_TYPE        2
`define MDA_F_BURST       6:4
`define MDA_F_TBINTDIS    7
`define MDA_F_SINC        9:8
`define MDA_F_DINC        11:10
`define MDA_F_WIDTH       13:12
`define MDA_F_CNT         29:16

// ==========================================================================
// Encodings
`define MDA_OP_IDLE       2'h0
`define MDA_OP_BASIC      2'h1
`define MDA_OP_SG         2'h2
`define MDA_RESP_OKAY     2'h0
`define MDA_RESP_SLVERR   2'h2

`endif

// [hdl/mda_pkg.sv]
// Types shared by the DMA controller modules
package mda_pkg;

  // ========================================================================
  // Engine states
  typedef enum logic [1:0] {
    MDA_S_IDLE = 2'b00,
    MDA_S_LOAD = 2'b01,
    MDA_S_RD   = 2'b10,
    MDA_S_WR   = 2'b11
  } mda_state_t;

endpackage

// [hdl/mda_arbiter.sv]
// Two-level channel arbiter, fixed level before the rest, highest channel number first within each level
`timescale 1ns/1ns
`default_nettype none
module mda_arbiter #(
  parameter int NCH = 12
) (
  // Requests
  input  wire logic [NCH-1:0]         pending,
  input  wire logic [NCH-1:0]         fixed_lvl,
  // Grant
  output logic                        grant_valid,
  output logic [$clog2(NCH)-1:0]      grant_ch
);

  // ========================================================================
  // Fixed level scanned after round-robin so it overrides
  always_comb begin
    grant_valid = 1'b0;
    grant_ch    = '0;
    for (int i = 0; i < NCH; i++) begin
      if (pending[i] && !fixed_lvl[i]) begin // RL3
        grant_valid = 1'b1;
        grant_ch    = i[$clog2(NCH)-1:0];
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (pending[i] && fixed_lvl[i]) begin // RL2
        grant_valid = 1'b1;
        grant_ch    = i[$clog2(NCH)-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// [hdl/mda_dma.sv]
// Twelve-channel DMA controller with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mda_regs.svh"

// Operation
// RL1 - Twelve independent channels each move memory-to-memory or peripheral.
// RL2 - Any pending fixed-level channel is served before round-robin ones.
// RL3 - Within a level the higher channel number is served first.
// RL4 - A channel level bit of one means fixed, zero means round-robin.
// RL5 - Each item is 8, 16 or 32 bits wide as the descriptor selects.
// RL6 - Source and destination step by byte, half-word, word or not at all.
// RL7 - Requests come from software or peripheral lines; memory copies by software.
// RL8 - Single type moves exactly one item for each request.
// RL9 - Burst type moves many items for one request.
// RL10 - Basic mode runs one descriptor, scatter-gather walks a chain.
// RL11 - A descriptor holds addresses, count, burst, type and mode.
// RL12 - Software enables the controller clock before use.
// RL13 - A finished basic task returns to idle and flags completion.
// RL14 - Mode idle is 0 and scatter-gather 2, fetching from base plus link.
// RL15 - The count drops per item or per burst and the task ends at zero.
// RL16 - Software uses burst type only for memory-to-memory copies.
// RL17 - Arbitration happens only between whole items or bursts.
module mda_dma
  import mda_pkg::*;
#(
  parameter int NCH = `MDA_NUM_CH
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]       s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [11:0]       s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // Peripheral side
  input  wire logic [NCH-1:0]    periph_req,
  input  wire logic              dma_clock_enable_bit,
  // Memory port
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [31:0]            mem_addr,
  output logic [31:0]            mem_wdata,
  output logic [1:0]             mem_size,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  // Interrupt
  output logic                   irq
);

  localparam int CW = $clog2(NCH);

  // ========================================================================
  // Helpers
  function automatic logic [31:0] step_of(input logic [1:0] code);
    case (code)
      2'h0:    step_of = 32'h0000_0001;
      2'h1:    step_of = 32'h0000_0002;
      2'h2:    step_of = 32'h0000_0004;
      default: step_of = 32'h0000_0000;
    endcase
  endfunction

  // Burst code 0 gives 128 items, each step halves it
  function automatic logic [13:0] burst_of(input logic [2:0] code);
    burst_of = 14'h0080 >> code;
  endfunction

  // ========================================================================
  // Storage
  logic [31:0]      ctl_q  [NCH];
  logic [31:0]      src_q  [NCH];
  logic [31:0]      dst_q  [NCH];
  logic [31:0]      nxt_q  [NCH];
  logic [31:0]      scat_base_q;
  logic [NCH-1:0]   fixed_q;
  logic [NCH-1:0]   mask_q;
  logic [NCH-1:0]   sts_q;
  logic [NCH-1:0]   req_q;
  logic [NCH-1:0]   loaded_q;
  logic [NCH-1:0]   fin_q;
  logic [NCH-1:0]   sw_set_q;
  mda_state_t       state_q;
  logic [CW-1:0]    ch_q;
  logic [1:0]       word_q;
  logic [13:0]      left_q;
  logic [13:0]      chunk_q;
  logic             grant_valid;
  logic [CW-1:0]    grant_ch;

  // ========================================================================
  // Bus handshake
  logic             wr_fire;
  logic             rd_fire;
  logic [11:0]      waddr;
  logic [11:0]      raddr;
  logic             dsc_w;
  logic [CW-1:0]    dsc_wch;

  assign waddr   = s_awaddr;
  assign raddr   = s_araddr;
  assign wr_fire = s_awvalid && s_wvalid && !s_awready && !s_bvalid;
  assign rd_fire = s_arvalid && !s_arready && !s_rvalid;
  assign dsc_w   = wr_fire && (waddr < `MDA_DSC_LIMIT);
  assign dsc_wch = waddr[4+CW-1:4];

  // Address and data taken together, response follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `MDA_RESP_OKAY;
    end else begin
      s_awready <= wr_fire;
      s_wready  <= wr_fire;
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (waddr < `MDA_DSC_LIMIT ||
                     (waddr >= `MDA_OFS_SCAT_BASE &&
                      waddr <= `MDA_OFS_STATUS)) ?
                    `MDA_RESP_OKAY : `MDA_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= `MDA_RESP_OKAY;
    end else begin
      s_arready <= rd_fire;
      if (rd_fire) begin
        s_rvalid <= 1'b1;
        s_rresp  <= `MDA_RESP_OKAY;
        s_rdata  <= 32'h0000_0000;
        if (raddr < `MDA_DSC_LIMIT) begin
          case (raddr[3:2])
            `MDA_W_CTL:  s_rdata <= ctl_q[raddr[4+CW-1:4]];
            `MDA_W_SRC:  s_rdata <= src_q[raddr[4+CW-1:4]];
            `MDA_W_DST:  s_rdata <= dst_q[raddr[4+CW-1:4]];
            default:     s_rdata <= nxt_q[raddr[4+CW-1:4]];
          endcase
        end else begin
          case (raddr)
            `MDA_OFS_SCAT_BASE: s_rdata <= scat_base_q;
            `MDA_OFS_SW_REQ:    s_rdata <= {{(32-NCH){1'b0}}, req_q};
            `MDA_OFS_FIXED_LVL: s_rdata <= {{(32-NCH){1'b0}}, fixed_q};
            `MDA_OFS_INT_MASK:  s_rdata <= {{(32-NCH){1'b0}}, mask_q};
            `MDA_OFS_INT_STS:   s_rdata <= {{(32-NCH){1'b0}}, sts_q};
            `MDA_OFS_STATUS:    s_rdata <= {{(31-CW){1'b0}}, ch_q,
                                            state_q != MDA_S_IDLE};
            default:            s_rresp <= `MDA_RESP_SLVERR;
          endcase
        end
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Global control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scat_base_q <= 32'h0000_0000;
      fixed_q     <= '0;
      mask_q      <= '0;
      sw_set_q    <= '0;
    end else begin
      sw_set_q <= '0;
      if (wr_fire) begin
        case (waddr)
          `MDA_OFS_SCAT_BASE: scat_base_q <= {s_wdata[31:16], 16'h0000};
          `MDA_OFS_SW_REQ:    sw_set_q    <= s_wdata[NCH-1:0]; // RL7
          `MDA_OFS_FIXED_LVL: fixed_q     <= s_wdata[NCH-1:0]; // RL4
          `MDA_OFS_INT_MASK:  mask_q      <= s_wdata[NCH-1:0];
          default: ;
        endcase
      end
    end
  end

  // Hardware set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq   <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~((wr_fire && waddr == `MDA_OFS_INT_STS) ?
                s_wdata[NCH-1:0] : {NCH{1'b0}})) | fin_q;
      irq   <= |(sts_q & mask_q); // RL13
    end
  end

  // ========================================================================
  // Arbitration, only consulted from the idle state
  mda_arbiter #(.NCH(NCH)) u_arb (
    .pending     (req_q),
    .fixed_lvl   (fixed_q),
    .grant_valid (grant_valid),
    .grant_ch    (grant_ch)
  );

  // ========================================================================
  // Engine and descriptor storage
  logic [31:0] gctl;
  logic [31:0] cctl;
  logic [13:0] gcnt;
  logic [13:0] gchunk;

  assign gctl   = ctl_q[grant_ch];
  assign cctl   = ctl_q[ch_q];
  assign gcnt   = gctl[`MDA_F_CNT];
  // Single moves one item, burst a whole chunk
  assign gchunk = !gctl[`MDA_F_TYPE] ? 14'h0001 :
                  (burst_of(gctl[`MDA_F_BURST]) < gcnt) ?
                  burst_of(gctl[`MDA_F_BURST]) : gcnt; // RL8 RL9

  always_ff @(posedge aclk) begin
    logic [NCH-1:0] clr;
    logic [13:0]    rest;
    clr  = '0;
    rest = '0;
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_q[i] <= 32'h0000_0000;
        src_q[i] <= 32'h0000_0000;
        dst_q[i] <= 32'h0000_0000;
        nxt_q[i] <= 32'h0000_0000;
      end
      state_q   <= MDA_S_IDLE;
      ch_q      <= '0;
      word_q    <= 2'h0;
      left_q    <= 14'h0000;
      chunk_q   <= 14'h0000;
      req_q     <= '0;
      loaded_q  <= '0;
      fin_q     <= '0;
      {mem_req, mem_we} <= 2'b00;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_size  <= 2'h0;
    end else begin
      fin_q <= '0;
      if (dsc_w) begin // RL11
        case (waddr[3:2])
          `MDA_W_CTL: begin
            ctl_q[dsc_wch]    <= s_wdata;
            loaded_q[dsc_wch] <= 1'b0;
          end
          `MDA_W_SRC: src_q[dsc_wch] <= s_wdata;
          `MDA_W_DST: dst_q[dsc_wch] <= s_wdata;
          default:    nxt_q[dsc_wch] <= s_wdata;
        endcase
      end
      case (state_q)
        MDA_S_IDLE: begin
          if (grant_valid && dma_clock_enable_bit) begin // RL17 RL12
            ch_q <= grant_ch;
            if (gctl[`MDA_F_OP] == `MDA_OP_SG &&
                !loaded_q[grant_ch]) begin
              word_q   <= 2'h0;
              {mem_req, mem_we} <= 2'b10;
              mem_size <= 2'h2;
              mem_addr <= scat_base_q +
                          {16'h0000, nxt_q[grant_ch][15:2], 2'b00}; // RL14
              state_q  <= MDA_S_LOAD;
            end else if (gctl[`MDA_F_OP] == `MDA_OP_IDLE ||
                         gcnt == 14'h0000) begin
              // Idle request is dropped but still reported
              clr[grant_ch]   = 1'b1;
              fin_q[grant_ch] <= 1'b1;
            end else begin
              chunk_q  <= gchunk;
              left_q   <= gchunk;
              if (!gctl[`MDA_F_TYPE]) begin
                clr[grant_ch] = 1'b1; // RL8
              end
              {mem_req, mem_we} <= 2'b10;
              mem_size <= gctl[`MDA_F_WIDTH];
              mem_addr <= src_q[grant_ch];
              state_q  <= MDA_S_RD;
            end
          end
        end
        MDA_S_LOAD: begin
          if (mem_ack) begin // RL10
            case (word_q)
              `MDA_W_CTL: ctl_q[ch_q] <= mem_rdata;
              `MDA_W_SRC: src_q[ch_q] <= mem_rdata;
              `MDA_W_DST: dst_q[ch_q] <= mem_rdata;
              default:    nxt_q[ch_q] <= mem_rdata;
            endcase
            word_q   <= word_q + 2'h1;
            mem_addr <= mem_addr + 32'h0000_0004;
            if (word_q == `MDA_W_NEXT) begin
              mem_req        <= 1'b0;
              loaded_q[ch_q] <= 1'b1;
              state_q        <= MDA_S_IDLE;
            end
          end
        end
        MDA_S_RD: begin
          if (mem_ack) begin
            mem_we   <= 1'b1;
            mem_addr <= dst_q[ch_q];
            mem_wdata <= mem_rdata >> {mem_addr[1:0], 3'b000}
                         << {dst_q[ch_q][1:0], 3'b000}; // RL5
            state_q  <= MDA_S_WR;
          end
        end
        MDA_S_WR: begin
          if (mem_ack) begin
            src_q[ch_q] <= src_q[ch_q] + step_of(cctl[`MDA_F_SINC]); // RL6
            dst_q[ch_q] <= dst_q[ch_q] + step_of(cctl[`MDA_F_DINC]); // RL6
            if (left_q > 14'h0001) begin
              // Rest of the burst, no new request needed
              left_q   <= left_q - 14'h0001; // RL9
              mem_we   <= 1'b0;
              mem_addr <= src_q[ch_q] + step_of(cctl[`MDA_F_SINC]);
              state_q  <= MDA_S_RD;
            end else begin
              rest = cctl[`MDA_F_CNT] - chunk_q; // RL15
              {mem_req, mem_we} <= 2'b00;
              state_q <= MDA_S_IDLE;
              ctl_q[ch_q][`MDA_F_CNT] <= rest;
              if (rest == 14'h0000) begin
                if (cctl[`MDA_F_OP] == `MDA_OP_SG) begin
                  // Next arbitration fetches the following entry
                  loaded_q[ch_q] <= 1'b0;
                  fin_q[ch_q]    <= !cctl[`MDA_F_TBINTDIS];
                end else begin
                  clr[ch_q] = 1'b1;
                  ctl_q[ch_q][`MDA_F_OP] <= `MDA_OP_IDLE; // RL13
                  fin_q[ch_q]            <= 1'b1;
                end
              end
            end
          end
        end
        default: state_q <= MDA_S_IDLE;
      endcase
      // New requests win over clears in the same cycle
      req_q <= (req_q & ~clr) | periph_req | sw_set_q; // RL7 RL1
    end
  end

endmodule
`default_nettype wire

// [verif/mda_dma_chk.sv]
// Bus and engine checker for the DMA controller
`timescale 1ns/1ns
`default_nettype none
module mda_dma_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // Engine
  input wire logic        dma_clock_enable_bit,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Register bus
  property p_wr_take;
    s_awvalid && s_wvalid && !s_bvalid && !s_awready |=> s_awready && s_wready;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not taken");
  property p_wr_resp;
    s_awready |-> s_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_aw_pulse;
    s_awready |=> !s_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_rd_take;
    s_arvalid && !s_arready && !s_rvalid |=> s_arready && s_rvalid;
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not taken");
  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  // ==========================================================
  // Engine
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("access moved");
  property p_mem_gate;
    $rose(mem_req) |-> $past(dma_clock_enable_bit);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("grant while off");
endmodule
bind mda_dma mda_dma_chk u_mda_dma_chk (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .dma_clock_enable_bit(dma_clock_enable_bit),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_ack(mem_ack)
);
`default_nettype wire

// [verif/mda_mem_model.sv]
// Behavioural system memory answering the engine's port
`timescale 1ns/1ns
`default_nettype none
module mda_mem_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  output var  logic        mem_ack,
  output var  logic [31:0] mem_rdata,
  // Wait cycles before each answer
  input  wire logic [3:0]  slow
);
  logic [31:0] mem [0:255];
  logic [3:0]  wait_q;
  logic [3:0]  lane;
  // Only the low address bits decode, so high bases alias down
  assign lane = (mem_size == 2'h2) ? 4'hF :
                (mem_size == 2'h1) ? (4'h3 << {mem_addr[1], 1'b0}) :
                (4'h1 << mem_addr[1:0]);
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    // Released data bus toggles so stale data is never mistaken
    mem_rdata <= ~mem_rdata;
    if (!aresetn) begin
      wait_q <= 4'h0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else if (mem_req && !mem_ack) begin
      if (wait_q < slow) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          for (int b = 0; b < 4; b++) begin
            if (lane[b]) mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
          end
        end else begin
          mem_rdata <= mem[mem_addr[9:2]];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb_mda_dma.sv]
// Self-checking bench for the DMA controller
`timescale 1ns/1ns
`default_nettype none
`include "mda_regs.svh"
module tb_mda_dma;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
  logic        s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [11:0] s_awaddr, s_araddr, periph_req;
  logic [31:0] s_wdata, s_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [3:0]  s_wstrb, slow;
  logic [1:0]  s_bresp, s_rresp, mem_size;
  logic        dma_clock_enable_bit, mem_req, mem_we, mem_ack, irq;
  int          num_errors, checks;
  integer      seed;
  logic [31:0] img [0:255];
  logic [1:0]  exp_b [$];
  logic [65:0] exp_r [$];
  logic [31:0] exp_w [$];
  mda_dma u_mda_dma (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .periph_req(periph_req),
    .dma_clock_enable_bit(dma_clock_enable_bit), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .irq(irq)
  );
  mda_mem_model u_mda_mem_model (
    .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow)
  );
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========================================================
  // Helpers
  task automatic cmp(input logic [31:0] got, exp, m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got & m, exp & m);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    exp_b.push_back(r);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1) {s_awvalid, s_bready} <= 2'b01;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while ({s_bvalid, s_bready} !== 2'b11);
    s_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, m,
                        input logic [1:0] r);
    @(posedge aclk);
    exp_r.push_back({r, m, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) {s_arvalid, s_rready} <= 2'b01;
    end while ({s_rvalid, s_rready} !== 2'b11);
    s_rready <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] op, input logic t,
      input logic [2:0] bc, input logic [1:0] si, di, w, input logic [13:0] n);
    ctl = 32'h0;
    ctl[`MDA_F_OP] = op;
    ctl[`MDA_F_TYPE] = t;
    ctl[`MDA_F_BURST] = bc;
    ctl[`MDA_F_SINC] = si;
    ctl[`MDA_F_DINC] = di;
    ctl[`MDA_F_WIDTH] = w;
    ctl[`MDA_F_CNT] = n;
  endfunction
  task automatic cfg(input logic [3:0] ch, input logic [31:0] c, s, d, n);
    axi_wr({4'h0, ch, 4'h4}, s, `MDA_RESP_OKAY);
    axi_wr({4'h0, ch, 4'h8}, d, `MDA_RESP_OKAY);
    axi_wr({4'h0, ch, 4'hC}, n, `MDA_RESP_OKAY);
    axi_wr({4'h0, ch, 4'h0}, c, `MDA_RESP_OKAY);
  endtask
  task automatic pulse;
    @(posedge aclk);
    periph_req <= 12'h002;
    @(posedge aclk);
    periph_req <= 12'h000;
  endtask
  task automatic drain;
    while (exp_w.size() != 0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Result watcher: every write and answer pops the oldest note
  always @(posedge aclk) begin
    if (s_bvalid === 1'b1 && s_bready === 1'b1) begin
      cmp({30'h0, s_bresp}, {30'h0, exp_b.pop_front()}, ALL);
    end
    if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
      cmp({30'h0, s_rresp}, {30'h0, exp_r[0][65:64]}, ALL);
      cmp(s_rdata, exp_r[0][31:0], exp_r[0][63:32]);
      exp_r.pop_front();
    end
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
      if (exp_w.size() == 0) cmp(mem_addr, ~mem_addr, ALL);
      else cmp(mem_addr, exp_w.pop_front(), ALL);
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    conclude();
  end
  // ==========================================================
  // Tests
  initial begin
    int ord [4];
    seed = 32'h476C434E;
    ord = '{5, 2, 9, 3};
    for (int i = 0; i < 256; i++) begin
      img[i] = $random(seed);
      u_mda_mem_model.mem[i] = img[i];
    end
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 6'h0;
    {s_awaddr, s_araddr, periph_req} <= 36'h0;
    s_wdata <= 32'h0;
    s_wstrb <= 4'hF;
    dma_clock_enable_bit <= 1'b0;
    slow <= 4'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(12'h000, 32'h0, ALL, `MDA_RESP_OKAY);
    axi_wr(`MDA_OFS_FIXED_LVL, 32'h024, `MDA_RESP_OKAY);
    axi_rd(`MDA_OFS_FIXED_LVL, 32'h024, ALL, `MDA_RESP_OKAY);
    axi_wr(12'h800, 32'h1, `MDA_RESP_SLVERR);
    axi_rd(12'h800, 32'h0, ALL, `MDA_RESP_SLVERR);
    $display("test registers done");
    foreach (ord[i]) cfg(4'(ord[i]), ctl(2'h1, 1'b0, 3'h0, 2'h2, 2'h2,
      2'h2, 14'h1), 32'h40 + 4 * ord[i], 32'h80 + 4 * ord[i], 32'h0);
    // Software request line, clock enable held off first
    axi_wr(`MDA_OFS_SW_REQ, 32'h2AC, `MDA_RESP_OKAY);
    repeat (20) @(posedge aclk);
    foreach (ord[i]) exp_w.push_back(32'h80 + 4 * ord[i]);
    dma_clock_enable_bit <= 1'b1;
    drain();
    for (int i = 0; i < 4; i++) cmp(u_mda_mem_model.mem[32 + ord[i]],
      img[16 + ord[i]], ALL);
    axi_rd(`MDA_OFS_INT_STS, 32'h2AC, ALL, `MDA_RESP_OKAY);
    axi_rd(12'h050, 32'h0, 32'h3, `MDA_RESP_OKAY);
    axi_wr(`MDA_OFS_INT_MASK, 32'h200, `MDA_RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h1, ALL);
    axi_wr(`MDA_OFS_INT_STS, 32'h200, `MDA_RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp({31'h0, irq}, 32'h0, ALL);
    axi_wr(`MDA_OFS_INT_STS, 32'hFFF, `MDA_RESP_OKAY);
    axi_rd(`MDA_OFS_INT_STS, 32'h0, ALL, `MDA_RESP_OKAY);
    $display("test priority done");
    slow <= 4'h3;
    cfg(4'h0, ctl(2'h1, 1'b1, 3'h4, 2'h0, 2'h0, 2'h0, 14'h10), 32'h100,
      32'h200, 32'h0);
    cfg(4'h1, ctl(2'h1, 1'b0, 3'h0, 2'h3, 2'h1, 2'h1, 14'h2), 32'h300,
      32'h240, 32'h0);
    for (int i = 0; i < 8; i++) exp_w.push_back(32'h200 + i);
    exp_w.push_back(32'h240);
    for (int i = 8; i < 16; i++) exp_w.push_back(32'h200 + i);
    exp_w.push_back(32'h242);
    axi_wr(`MDA_OFS_SW_REQ, 32'h001, `MDA_RESP_OKAY);
    while (mem_req !== 1'b1) @(posedge aclk);
    pulse();
    while (exp_w.size() > 1) @(posedge aclk);
    pulse();
    drain();
    for (int i = 0; i < 4; i++) cmp(u_mda_mem_model.mem[128 + i],
      img[64 + i], ALL);
    cmp(u_mda_mem_model.mem[144], {2{img[192][15:0]}}, ALL);
    $display("test burst done");
    slow <= 4'($random(seed) & 3);
    axi_wr(`MDA_OFS_SCAT_BASE, 32'h0001_0000, `MDA_RESP_OKAY);
    u_mda_mem_model.mem[224] = ctl(2'h1, 1'b1, 3'h6, 2'h2, 2'h2, 2'h2, 14'h2);
    u_mda_mem_model.mem[225] = 32'h3C0;
    u_mda_mem_model.mem[226] = 32'h3D0;
    u_mda_mem_model.mem[227] = 32'h0;
    cfg(4'h4, ctl(2'h2, 1'b1, 3'h0, 2'h0, 2'h0, 2'h0, 14'h0), 32'h0,
      32'h0, 32'h380);
    exp_w.push_back(32'h3D0);
    exp_w.push_back(32'h3D4);
    axi_wr(`MDA_OFS_SW_REQ, 32'h010, `MDA_RESP_OKAY);
    drain();
    cmp(u_mda_mem_model.mem[244], img[240], ALL);
    cmp(u_mda_mem_model.mem[245], img[241], ALL);
    axi_rd(`MDA_OFS_INT_STS, 32'h010, 32'h010, `MDA_RESP_OKAY);
    $display("test chain done");
    conclude();
  end
endmodule
`default_nettype wire
